/* logic/sar_pkg.sv */
// Shared constants and types for the serial converter readout link.
package sar_pkg;
  localparam int SAR_RESULT_W = 14;
  localparam int SAR_TIMER_W = 10;
  localparam int SAR_PTR_W = 4;
  localparam int SAR_CNT_W = 4;
  localparam int SAR_CLK_PERIOD_NS = 5;
  // Conversion time window seen by the host, and the time the device really takes.
  localparam int SAR_TCONV_MIN_NS = 500;
  localparam int SAR_TCONV_MAX_NS = 1600;
  localparam int SAR_TCONV_DEV_NS = 1400;
  // Host drops its select this long after the start edge when it asks for the start bit.
  localparam int SAR_SEL_PULSE_NS = 100;
  localparam int SAR_SCK_HALF_NS = 80;
  // Least times round up, the device's conversion time (a longest time) rounds down.
  localparam int SAR_TCONV_MAX_CYC = (SAR_TCONV_MAX_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
  localparam int SAR_TCONV_DEV_CYC = SAR_TCONV_DEV_NS / SAR_CLK_PERIOD_NS;
  localparam int SAR_SEL_PULSE_CYC = (SAR_SEL_PULSE_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
  localparam int SAR_SCK_HALF_CYC = (SAR_SCK_HALF_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
  localparam int SAR_BUSY_WAIT_CYC = 2 * SAR_TCONV_MAX_CYC;
  localparam logic [SAR_TIMER_W-1:0] SAR_TCONV_MAX_CNT = SAR_TCONV_MAX_CYC[SAR_TIMER_W-1:0];
  localparam logic [SAR_TIMER_W-1:0] SAR_TCONV_DEV_LAST = 10'(SAR_TCONV_DEV_CYC - 1);
  localparam logic [SAR_TIMER_W-1:0] SAR_SEL_PULSE_CNT = SAR_SEL_PULSE_CYC[SAR_TIMER_W-1:0];
  localparam logic [SAR_TIMER_W-1:0] SAR_SCK_HALF_LAST = 10'(SAR_SCK_HALF_CYC - 1);
  localparam logic [SAR_TIMER_W-1:0] SAR_BUSY_WAIT_CNT = SAR_BUSY_WAIT_CYC[SAR_TIMER_W-1:0];
  // Falling-edge counts that end a readout without and with the start bit.
  localparam logic [SAR_CNT_W-1:0] SAR_LAST_FALL_PLAIN = 4'hD;
  localparam logic [SAR_CNT_W-1:0] SAR_LAST_FALL_BUSY = 4'hE;
  localparam logic [SAR_CNT_W-1:0] SAR_PULSES_PLAIN = 4'hE;
  localparam logic [SAR_CNT_W-1:0] SAR_PULSES_BUSY = 4'hF;
  localparam logic [SAR_RESULT_W-1:0] SAR_RESULT_RST = 14'h0000;
  // Pin filters start at the host's idle levels, serial input high and the rest low, so no false idle drive follows reset.
  localparam logic [2:0] SAR_PIN_IDLE = 3'h2;

  typedef enum logic [2:0] {
    SAR_DEV_IDLE = 3'b000,
    SAR_DEV_CONVERT = 3'b001,
    SAR_DEV_WAIT_SEL = 3'b010,
    SAR_DEV_SHIFT = 3'b011,
    SAR_DEV_CHAIN = 3'b100
  } sar_dev_state_t;

  typedef enum logic [2:0] {
    SAR_HST_IDLE = 3'b000,
    SAR_HST_CONV = 3'b001,
    SAR_HST_LOW = 3'b010,
    SAR_HST_HIGH = 3'b011,
    SAR_HST_END = 3'b100
  } sar_hst_state_t;
endpackage

/* logic/sar_link_if.sv */
// Serial link between the converter and its host, with the pulled-up data line.
`timescale 1ns/100ps
interface sar_link_if;
  logic convertStart;
  logic serialDataIn;
  logic sck;
  logic sdoOut;
  logic sdoOe;
  logic sdoLine;

  // The data line has a pull-up, so an undriven line reads high.
  assign sdoLine = sdoOe ? sdoOut : 1'b1;

  modport dev (
    input convertStart,
    input serialDataIn,
    input sck,
    output sdoOut,
    output sdoOe
  );

  modport host (
    output convertStart,
    output serialDataIn,
    output sck,
    input sdoLine
  );
endinterface

/* logic/sar_adc_device.sv */
// Converter end of the link: start sampling, conversion timing and serial result readout.
//
// Functional notes
// - Convert-start rise samples input: high gated, low chain.
// - Tied input and convert-start always pick chain.
// - Gated mode: busy if either line low at end.
// - Chain mode: busy only if clock high at start.
// - Without busy, host waits maximum conversion time.
// - Rise with input high: convert, gated, output released.
// - Started conversion always runs to completion.
// - Three-wire no busy: host restores convert-start in time.
// - Conversion end enters acquisition, powers down.
// - Three-wire no busy: convert-start fall drives top bit.
// - Falling clock edges shift bits, valid both edges.
// - Three-wire no busy: release at fall 14 or rise.
// - Three-wire busy: output released until conversion ends.
// - Three-wire busy: host holds convert-start low through window.
// - Busy: output driven low (gated) or high (chain) when conversion completes.
// - Gated busy: top bit first, release at fall 15 or rise.
// - Output survives contention; host keeps it short.
// - Four-wire: both lines low drive output low.
// - Four-wire no busy: host restores input in time.
// - Four-wire: input fall after conversion drives top bit.
// - Four-wire no busy: release at fall 14 or input rise.
`timescale 1ns/100ps
module sar_adc_device
  import sar_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  sar_link_if.dev link,
  input wire logic [SAR_RESULT_W-1:0] sampleValue,
  output logic converting,
  output logic acquiring
);
  // Link clock side: a gray-coded count of serial clock falling edges.
  logic [SAR_PTR_W-1:0] fallBin_q;
  logic [SAR_PTR_W-1:0] fallGray_q;
  wire [SAR_PTR_W-1:0] fallBinNext = fallBin_q + 4'h1;

  always_ff @(negedge link.sck or negedge rst_b) begin
    if (!rst_b) begin
      fallBin_q <= '0;
      fallGray_q <= '0;
    end else begin
      fallBin_q <= fallBinNext;
      fallGray_q <= fallBinNext ^ (fallBinNext >> 1);
    end
  end

  // Pin inputs: bit 0 convert-start, bit 1 serial input, bit 2 serial clock level.
  wire [2:0] pinRaw = {link.sck, link.serialDataIn, link.convertStart};
  logic [2:0] pinS1_q;
  logic [2:0] pinS2_q;
  logic [2:0] pinS3_q;
  logic [2:0] pinStb_q;
  logic [2:0] pinStbNext;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      // A change is taken once the second and third stages agree.
      assign pinStbNext[gi] = (pinS2_q[gi] == pinS3_q[gi]) ? pinS3_q[gi] : pinStb_q[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_q <= SAR_PIN_IDLE;
      pinS2_q <= SAR_PIN_IDLE;
      pinS3_q <= SAR_PIN_IDLE;
      pinStb_q <= SAR_PIN_IDLE;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinStb_q <= pinStbNext;
    end
  end

  // Falling-edge pointer crossing: two flops, then gray to binary.
  logic [SAR_PTR_W-1:0] grayS1_q;
  logic [SAR_PTR_W-1:0] grayS2_q;
  logic [SAR_PTR_W-1:0] ptrBin;
  logic [SAR_PTR_W-1:0] seenPtr_q;

  generate
    for (gi = 0; gi < SAR_PTR_W; gi++) begin : g_gray
      assign ptrBin[gi] = ^grayS2_q[SAR_PTR_W-1:gi];
    end
  endgenerate

  // One falling edge is consumed per cycle; the link clock is far slower than clk.
  wire fallStep = (seenPtr_q != ptrBin);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grayS1_q <= '0;
      grayS2_q <= '0;
      seenPtr_q <= '0;
    end else begin
      grayS1_q <= fallGray_q;
      grayS2_q <= grayS1_q;
      seenPtr_q <= fallStep ? seenPtr_q + 4'h1 : seenPtr_q;
    end
  end

  wire cnvLvl = pinStb_q[0];
  wire sdiLvl = pinStb_q[1];
  wire sckLvl = pinStb_q[2];
  wire cnvRise = pinStbNext[0] & ~pinStb_q[0];
  wire sdiRise = pinStbNext[1] & ~pinStb_q[1];

  sar_dev_state_t state_q;
  sar_dev_state_t state_d;
  logic [SAR_TIMER_W-1:0] timer_q;
  logic [SAR_TIMER_W-1:0] timer_d;
  logic [SAR_RESULT_W-1:0] shift_q;
  logic [SAR_RESULT_W-1:0] shift_d;
  logic [SAR_CNT_W-1:0] fallCnt_q;
  logic [SAR_CNT_W-1:0] fallCnt_d;
  logic gatedMode_q;
  logic gatedMode_d;
  logic chainBusy_q;
  logic chainBusy_d;
  logic startBit_q;
  logic startBit_d;
  logic busyUsed_q;
  logic busyUsed_d;
  logic selByCnv_q;
  logic selByCnv_d;
  logic sdoOe_q;
  logic sdoOut_q;

  // The select line that ends a gated readout: convert-start on three wires, serial input on four.
  wire selRise = selByCnv_q ? cnvRise : sdiRise;
  wire lineBusy = ~cnvLvl | ~sdiLvl;
  wire [SAR_CNT_W-1:0] lastFall = busyUsed_q ? SAR_LAST_FALL_BUSY : SAR_LAST_FALL_PLAIN;
  wire convDone = (state_q == SAR_DEV_CONVERT) && (timer_q == SAR_TCONV_DEV_LAST);

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    shift_d = shift_q;
    fallCnt_d = fallCnt_q;
    gatedMode_d = gatedMode_q;
    chainBusy_d = chainBusy_q;
    startBit_d = startBit_q;
    busyUsed_d = busyUsed_q;
    selByCnv_d = selByCnv_q;
    if (cnvRise && state_q != SAR_DEV_CONVERT) begin
      // Old stable levels are used so a serial input tied to convert-start reads low.
      state_d = SAR_DEV_CONVERT;
      timer_d = '0;
      gatedMode_d = sdiLvl;
      chainBusy_d = sckLvl;
      shift_d = sampleValue;
      startBit_d = 1'b0;
      busyUsed_d = 1'b0;
      fallCnt_d = '0;
    end else begin
      case (state_q)
        SAR_DEV_IDLE: begin
          state_d = SAR_DEV_IDLE;
        end
        SAR_DEV_CONVERT: begin
          // Convert-start is not looked at until the timer expires.
          timer_d = timer_q + 10'h001;
          if (convDone) begin
            fallCnt_d = '0;
            if (!gatedMode_q) begin
              state_d = SAR_DEV_CHAIN;
              startBit_d = chainBusy_q;
            end else if (lineBusy) begin
              state_d = SAR_DEV_SHIFT;
              startBit_d = 1'b1;
              busyUsed_d = 1'b1;
              selByCnv_d = ~cnvLvl;
            end else begin
              state_d = SAR_DEV_WAIT_SEL;
            end
          end
        end
        SAR_DEV_WAIT_SEL: begin
          if (!cnvLvl) begin
            state_d = SAR_DEV_SHIFT;
            selByCnv_d = 1'b1;
          end else if (!sdiLvl) begin
            state_d = SAR_DEV_SHIFT;
            selByCnv_d = 1'b0;
          end
        end
        SAR_DEV_SHIFT: begin
          if (selRise) begin
            state_d = SAR_DEV_IDLE;
          end else if (fallStep) begin
            fallCnt_d = fallCnt_q + 4'h1;
            startBit_d = 1'b0;
            if (!startBit_q) begin
              shift_d = {shift_q[SAR_RESULT_W-2:0], 1'b0};
            end
            if (fallCnt_q == lastFall) begin
              state_d = SAR_DEV_IDLE;
            end
          end
        end
        SAR_DEV_CHAIN: begin
          if (!cnvLvl) begin
            state_d = SAR_DEV_IDLE;
          end else if (fallStep) begin
            startBit_d = 1'b0;
            if (!startBit_q) begin
              shift_d = {shift_q[SAR_RESULT_W-2:0], sdiLvl};
            end
          end
        end
        default: begin
          state_d = SAR_DEV_IDLE;
        end
      endcase
    end
  end

  // Output decode from the next state, so the pin follows its cause by one flop.
  wire inReadout = (state_d == SAR_DEV_SHIFT) || (state_d == SAR_DEV_CHAIN);
  wire bothLow = (state_d == SAR_DEV_IDLE) && !cnvLvl && !sdiLvl;
  wire sdoOeD = inReadout | bothLow;
  wire startLevel = (state_d == SAR_DEV_CHAIN);
  wire sdoOutD = !inReadout ? 1'b0 : (startBit_d ? startLevel : shift_d[SAR_RESULT_W-1]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SAR_DEV_IDLE;
      timer_q <= '0;
      shift_q <= SAR_RESULT_RST;
      fallCnt_q <= '0;
      gatedMode_q <= 1'b1;
      chainBusy_q <= 1'b0;
      startBit_q <= 1'b0;
      busyUsed_q <= 1'b0;
      selByCnv_q <= 1'b1;
      sdoOe_q <= 1'b0;
      sdoOut_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      shift_q <= shift_d;
      fallCnt_q <= fallCnt_d;
      gatedMode_q <= gatedMode_d;
      chainBusy_q <= chainBusy_d;
      startBit_q <= startBit_d;
      busyUsed_q <= busyUsed_d;
      selByCnv_q <= selByCnv_d;
      sdoOe_q <= sdoOeD;
      sdoOut_q <= sdoOutD;
    end
  end

  // Contention with another converter is a board matter; the driver itself is plain.
  assign link.sdoOe = sdoOe_q;
  assign link.sdoOut = sdoOut_q;
  assign converting = (state_q == SAR_DEV_CONVERT);
  assign acquiring = (state_q != SAR_DEV_CONVERT);
endmodule // sar_adc_device

/* logic/sar_adc_host.sv */
// Host end of the link: starts a conversion, waits or watches for the start bit, reads the result.
`timescale 1ns/100ps
module sar_adc_host
  import sar_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  sar_link_if.host link,
  input wire logic start,
  input wire logic fourWire,
  input wire logic useBusy,
  output logic ready,
  output logic resultValid,
  output logic [SAR_RESULT_W-1:0] result
);
  // The data line comes from another domain: three flops and an agreement filter.
  logic sdoS1_q;
  logic sdoS2_q;
  logic sdoS3_q;
  logic sdoStb_q;
  wire sdoStbNext = (sdoS2_q == sdoS3_q) ? sdoS3_q : sdoStb_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdoS1_q <= 1'b1;
      sdoS2_q <= 1'b1;
      sdoS3_q <= 1'b1;
      sdoStb_q <= 1'b1;
    end else begin
      sdoS1_q <= link.sdoLine;
      sdoS2_q <= sdoS1_q;
      sdoS3_q <= sdoS2_q;
      sdoStb_q <= sdoStbNext;
    end
  end

  sar_hst_state_t state_q;
  sar_hst_state_t state_d;
  logic [SAR_TIMER_W-1:0] timer_q;
  logic [SAR_TIMER_W-1:0] timer_d;
  logic [SAR_CNT_W-1:0] pulse_q;
  logic [SAR_CNT_W-1:0] pulse_d;
  logic [SAR_RESULT_W-1:0] data_q;
  logic [SAR_RESULT_W-1:0] data_d;
  logic [SAR_RESULT_W-1:0] result_q;
  logic [SAR_RESULT_W-1:0] result_d;
  logic cnv_q;
  logic cnv_d;
  logic sdi_q;
  logic sdi_d;
  logic sck_q;
  logic sck_d;
  logic four_q;
  logic four_d;
  logic busy_q;
  logic busy_d;
  logic valid_q;
  logic valid_d;
  logic selDropped_q;
  logic selDropped_d;

  wire [SAR_CNT_W-1:0] pulseTotal = busy_q ? SAR_PULSES_BUSY : SAR_PULSES_PLAIN;
  wire halfDone = (timer_q == SAR_SCK_HALF_LAST);
  wire dropBusy = busy_q && (timer_q == SAR_SEL_PULSE_CNT);
  wire dropPlain = !busy_q && (timer_q == SAR_TCONV_MAX_CNT);
  wire startSeen = busy_q && selDropped_q && !sdoStb_q;
  wire busyGiveUp = busy_q && (timer_q == SAR_BUSY_WAIT_CNT);
  wire skipCapture = busy_q && (pulse_q == 4'h0);

  always_comb begin
    state_d = state_q;
    timer_d = timer_q + 10'h001;
    pulse_d = pulse_q;
    data_d = data_q;
    result_d = result_q;
    cnv_d = cnv_q;
    sdi_d = sdi_q;
    sck_d = sck_q;
    four_d = four_q;
    busy_d = busy_q;
    valid_d = 1'b0;
    selDropped_d = selDropped_q;
    case (state_q)
      SAR_HST_IDLE: begin
        timer_d = '0;
        if (start) begin
          // Serial clock stays low at the start edge, so chain busy is never asked for.
          state_d = SAR_HST_CONV;
          cnv_d = 1'b1;
          sdi_d = 1'b1;
          four_d = fourWire;
          busy_d = useBusy;
          selDropped_d = 1'b0;
        end
      end
      SAR_HST_CONV: begin
        if (dropBusy || dropPlain) begin
          // Busy: select drops well before the least conversion time and stays low.
          if (four_q) begin
            sdi_d = 1'b0;
          end else begin
            cnv_d = 1'b0;
          end
          selDropped_d = 1'b1;
        end
        if (dropPlain || startSeen || busyGiveUp) begin
          state_d = SAR_HST_LOW;
          timer_d = '0;
          pulse_d = '0;
        end
      end
      SAR_HST_LOW: begin
        sck_d = 1'b0;
        if (halfDone) begin
          timer_d = '0;
          if (pulse_q == pulseTotal) begin
            state_d = SAR_HST_END;
          end else begin
            state_d = SAR_HST_HIGH;
            sck_d = 1'b1;
            if (!skipCapture) begin
              data_d = {data_q[SAR_RESULT_W-2:0], sdoStb_q};
            end
          end
        end
      end
      SAR_HST_HIGH: begin
        if (halfDone) begin
          state_d = SAR_HST_LOW;
          timer_d = '0;
          sck_d = 1'b0;
          pulse_d = pulse_q + 4'h1;
        end
      end
      SAR_HST_END: begin
        // Convert-start held high across a four-wire readback falls only now.
        state_d = SAR_HST_IDLE;
        cnv_d = 1'b0;
        sdi_d = 1'b1;
        result_d = data_q;
        valid_d = 1'b1;
      end
      default: begin
        state_d = SAR_HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SAR_HST_IDLE;
      timer_q <= '0;
      pulse_q <= '0;
      data_q <= SAR_RESULT_RST;
      result_q <= SAR_RESULT_RST;
      cnv_q <= 1'b0;
      sdi_q <= 1'b1;
      sck_q <= 1'b0;
      four_q <= 1'b0;
      busy_q <= 1'b0;
      valid_q <= 1'b0;
      selDropped_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      pulse_q <= pulse_d;
      data_q <= data_d;
      result_q <= result_d;
      cnv_q <= cnv_d;
      sdi_q <= sdi_d;
      sck_q <= sck_d;
      four_q <= four_d;
      busy_q <= busy_d;
      valid_q <= valid_d;
      selDropped_q <= selDropped_d;
    end
  end

  assign link.convertStart = cnv_q;
  assign link.serialDataIn = sdi_q;
  assign link.sck = sck_q;
  assign ready = (state_q == SAR_HST_IDLE);
  assign resultValid = valid_q;
  assign result = result_q;
endmodule // sar_adc_host

/* verification/sar_link_chk.sv */
// Concurrent checks on the link signals between the host end and the converter end.
`timescale 1ns/100ps
module sar_link_chk
  import sar_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic convertStart,
  input wire logic serialDataIn,
  input wire logic sck,
  input wire logic sdoOut,
  input wire logic sdoOe
);
  logic [9:0] hiCnt_q;
  logic [9:0] loCnt_q;
  logic [3:0] fallCnt_q;
  logic sckPrev_q;
  logic oePrev_q;
  logic busyRead_q;
  wire selLow = !convertStart || !serialDataIn;
  wire sckFall = sckPrev_q && !sck;
  wire oeRise = sdoOe && !oePrev_q;
  wire [9:0] hiCnt_d = !convertStart ? 10'h000 : hiCnt_q + {9'h000, hiCnt_q != 10'h3FF};
  wire [9:0] loCnt_d = !selLow ? 10'h000 : loCnt_q + {9'h000, loCnt_q != 10'h3FF};
  wire [3:0] fallCnt_d = !sdoOe ? 4'h0 : fallCnt_q + {3'h0, sckFall};
  // A long select-low stretch before the line turns on means a start bit leads the word.
  wire busyRead_d = oeRise ? (loCnt_q > 10'h064) : busyRead_q;
  wire [3:0] fallLimit = busyRead_q ? SAR_PULSES_BUSY : SAR_PULSES_PLAIN;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hiCnt_q <= 10'h000;
      loCnt_q <= 10'h000;
      fallCnt_q <= 4'h0;
      sckPrev_q <= 1'b0;
      oePrev_q <= 1'b0;
      busyRead_q <= 1'b0;
    end else begin
      hiCnt_q <= hiCnt_d;
      loCnt_q <= loCnt_d;
      fallCnt_q <= fallCnt_d;
      sckPrev_q <= sck;
      oePrev_q <= sdoOe;
      busyRead_q <= busyRead_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence sOffHeld;
    (!sdoOe)[*8];
  endsequence
  sequence sBitHeld;
    $stable(sdoOut)[*8];
  endsequence
  sequence sGatedSelDrop;
    $rose(convertStart) && serialDataIn ##30 selLow;
  endsequence

  a_start_release:
    assert property ($rose(convertStart) && serialDataIn |-> ##[1:8] sOffHeld)
    else $error("data line still driven after a gated start");
  a_conv_quiet:
    assert property ($rose(convertStart) && serialDataIn |-> ##200 !sdoOe)
    else $error("data line driven during conversion");
  a_busy_start:
    assert property (sGatedSelDrop |-> ##[240:270] (sdoOe && !sdoOut))
    else $error("start bit missing at conversion end");
  a_cnv_fall_msb:
    assert property ($fell(convertStart) && serialDataIn && hiCnt_q inside {[10'h12C:10'h190]} |-> ##[2:8] sdoOe)
    else $error("top bit not driven after convert-start fall");
  a_sdi_fall_msb:
    assert property ($fell(serialDataIn) && convertStart && hiCnt_q inside {[10'h12C:10'h190]} |-> ##[2:8] sdoOe)
    else $error("top bit not driven after serial input fall");
  a_release_count:
    assert property (sdoOe && fallCnt_q == fallLimit |-> ##[1:10] !sdoOe)
    else $error("data line not released after the last falling edge");
  a_sdi_release:
    assert property ($rose(serialDataIn) && $past(convertStart) |-> ##[1:8] !sdoOe)
    else $error("data line not released after serial input rise");
  a_bit_held:
    assert property ($rose(sck) && sdoOe |-> sBitHeld)
    else $error("data bit moved while clock high");
  a_fall_hold:
    assert property (sckFall && sdoOe && oePrev_q |-> $stable(sdoOut)[*2])
    else $error("data bit moved right at the falling edge");
endmodule // sar_link_chk

/* verification/sar_adc_serial_readout_tb.sv */
// Bench: host and converter joined, plus a bench-driven converter for chain and fault cases.
`timescale 1ns/100ps
module sar_adc_serial_readout_tb;
  import sar_pkg::*;
  logic clk;
  logic rst_b;
  logic start;
  logic fourWire;
  logic useBusy;
  logic ready;
  logic resultValid;
  logic converting;
  logic acquiring;
  logic [SAR_RESULT_W-1:0] result;
  logic [SAR_RESULT_W-1:0] sampleValue;
  logic [SAR_RESULT_W-1:0] sampleValue2;
  logic [SAR_RESULT_W-1:0] capWord;
  int bad_count;
  int n_compared;

  sar_link_if link ();
  sar_link_if link2 ();

  sar_adc_device sar_adc_device_i (.clk(clk), .rst_b(rst_b), .link(link), .sampleValue(sampleValue),
    .converting(converting), .acquiring(acquiring));
  sar_adc_host sar_adc_host_i (.clk(clk), .rst_b(rst_b), .link(link), .start(start), .fourWire(fourWire),
    .useBusy(useBusy), .ready(ready), .resultValid(resultValid), .result(result));
  // The second converter faces the bench so chain and misbehaving-host cases can be driven.
  sar_adc_device sar_adc_device_i2 (.clk(clk), .rst_b(rst_b), .link(link2), .sampleValue(sampleValue2),
    .converting(), .acquiring());
  sar_link_chk sar_link_chk_i (.clk(clk), .rst_b(rst_b), .convertStart(link.convertStart),
    .serialDataIn(link.serialDataIn), .sck(link.sck), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe));

  always #(SAR_CLK_PERIOD_NS / 2.0) clk = ~clk;

  // Bits as seen on the pulled-up line at each rising clock edge, MSB first.
  always @(posedge link.sck) capWord <= {capWord[SAR_RESULT_W-2:0], link.sdoLine};

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [SAR_RESULT_W-1:0] got, input logic [SAR_RESULT_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({13'h0000, got}, {13'h0000, exp});
  endtask

  task automatic host_read(input logic fw, input logic ub, input logic [SAR_RESULT_W-1:0] val);
    int n;
    tick(2);
    sampleValue = val;
    fourWire = fw;
    useBusy = ub;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(10);
    // The sample was taken at the start edge, so a later change must not reach the result.
    sampleValue = ~val;
    start = 1'b1;
    cmp_bit(ready, 1'b0);
    tick(1);
    start = 1'b0;
    tick(100);
    cmp_bit(converting, 1'b1);
    n = 0;
    while (resultValid !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n == 2000) begin
      bad_count++;
      tally_and_finish();
    end
    cmp_word(result, val);
    cmp_word(capWord, val);
    cmp_bit(link.sdoOe, 1'b0);
    cmp_bit(acquiring, 1'b1);
  endtask

  task automatic drv2(input logic convert_start, input logic serial_data_in, input logic sc, input int n);
    link2.convertStart = convert_start;
    link2.serialDataIn = serial_data_in;
    link2.sck = sc;
    tick(n);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    start = 1'b0;
    fourWire = 1'b0;
    useBusy = 1'b0;
    sampleValue = 14'h0000;
    sampleValue2 = 14'h2AAA;
    link2.convertStart = 1'b0;
    link2.serialDataIn = 1'b1;
    link2.sck = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tick(8);
    host_read(1'b0, 1'b0, 14'h2A5C);
    host_read(1'b0, 1'b1, 14'h1555);
    host_read(1'b1, 1'b0, 14'h3C3F);
    host_read(1'b1, 1'b1, 14'h0001);
    host_read(1'b0, 1'b0, 14'h0000);
    drv2(1'b0, 1'b0, 1'b0, 12);
    cmp_bit(link2.sdoOe, 1'b1);
    cmp_bit(link2.sdoLine, 1'b0);
    drv2(1'b1, 1'b1, 1'b0, 100);
    drv2(1'b0, 1'b0, 1'b0, 10);
    drv2(1'b1, 1'b1, 1'b0, 190);
    cmp_bit(link2.sdoOe, 1'b1);
    cmp_bit(link2.sdoLine, 1'b1);
    drv2(1'b1, 1'b1, 1'b1, 16);
    drv2(1'b1, 1'b1, 1'b0, 16);
    cmp_bit(link2.sdoLine, 1'b0);
    sampleValue2 = 14'h1555;
    drv2(1'b0, 1'b0, 1'b1, 12);
    drv2(1'b1, 1'b0, 1'b1, 300);
    cmp_bit(link2.sdoOe, 1'b1);
    cmp_bit(link2.sdoLine, 1'b1);
    drv2(1'b1, 1'b0, 1'b0, 16);
    cmp_bit(link2.sdoLine, 1'b0);
    drv2(1'b0, 1'b1, 1'b0, 12);
    drv2(1'b1, 1'b1, 1'b0, 20);
    cmp_bit(link2.sdoOe, 1'b0);
    // The host breaks the select timing here, so the start bit must appear.
    drv2(1'b0, 1'b1, 1'b0, 280);
    cmp_bit(link2.sdoOe, 1'b1);
    cmp_bit(link2.sdoLine, 1'b0);
    // A new start edge mid-readout restarts the conversion and frees the line.
    drv2(1'b1, 1'b1, 1'b0, 12);
    cmp_bit(link2.sdoOe, 1'b0);
    drv2(1'b1, 1'b1, 1'b0, 290);
    cmp_bit(link2.sdoOe, 1'b0);
    drv2(1'b1, 1'b0, 1'b0, 12);
    cmp_bit(link2.sdoOe, 1'b1);
    cmp_bit(link2.sdoLine, 1'b0);
    drv2(1'b1, 1'b1, 1'b0, 12);
    cmp_bit(link2.sdoOe, 1'b0);
    tally_and_finish();
  end
endmodule // sar_adc_serial_readout_tb
